// [port_statistics_counters.sv]
// Purpose: Per-port statistics counter bank with indirect read
// Assumes: Events are one-cycle pulses synchronous to clk
// Notes:   Global control value comes from the switch-wide register
`timescale 1ns/1ps
`include "stat_cfg.svh"
module port_statistics_counters (
   // Clock, enable and reset
   input  wire logic                 clk,
   input  wire logic                 ce,
   input  wire logic                 rst_n,
   // Per-port control-and-status write
   input  wire logic                 csr_wr,
   input  wire logic [31:0]          csr_wdata,
   // Switch-wide flush and freeze value
   input  wire logic [7:0]           glob_ctl,
   // Frame size and duplex settings
   input  wire logic                 max_len_alt,
   input  wire logic                 huge_only,
   input  wire logic                 half_duplex,
   // MAC events
   input  wire stat_pkg::rx_event_t  rx_evt,
   input  wire stat_pkg::tx_event_t  tx_evt,
   input  wire logic                 tx_late_coll,
   input  wire logic                 tx_coll,
   input  wire logic                 rx_drop,
   input  wire logic                 tx_drop,
   // Status toward software
   output logic [7:0]                csr_index_reg,
   output logic                      flush_en_reg,
   output logic                      rd_busy_reg,
   output logic [3:0]                data_hi_reg,
   output logic                      ovf_reg,
   output logic [31:0]               data_reg
);
   logic                   rst_meta_reg;
   logic                   rst_sync_n;
   stat_pkg::rd_state_t    state_reg;
   stat_pkg::rd_state_t    state_next;
   logic [13:0]            inc      [`NUM_CNT];
   logic [`WIDE_W-1:0]     cnt_val  [`NUM_CNT];
   logic                   cnt_ovf  [`NUM_CNT];
   logic [`NUM_CNT-1:0]    rd_clr;
   logic [5:0]             slot;
   logic                   slot_ok;
   logic                   frozen;
   logic                   flush;
   logic                   rx_v;
   logic                   tx_v;
   logic [13:0]            rx_len;
   logic [13:0]            tx_len;
   logic [13:0]            rx_max;
   logic                   rx_good;
   logic                   rx_err;
   logic                   tx_ok;
   logic [2:0]             bin;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n   <= rst_meta_reg;
      end
   end

   // Global control applies only to enabled ports
   assign frozen = flush_en_reg & glob_ctl[`GCTL_FREEZE_BIT];
   assign flush  = flush_en_reg & glob_ctl[`GCTL_FLUSH_BIT];

   // Map software index onto a counter slot
   always_comb begin
      slot    = csr_index_reg[5:0];
      slot_ok = 1'b0;
      if (csr_index_reg[7:5] == 3'h0) begin
         slot    = {1'b0, csr_index_reg[4:0]};
         slot_ok = 1'b1;
      end else if (csr_index_reg[7:2] == 6'(`IDX_EXT_BASE >> 2)) begin
         slot    = `SLOT_RX_TOTAL + {4'h0, csr_index_reg[1:0]};
         slot_ok = 1'b1;
      end
   end

   // Receive and transmit frame classification helpers
   assign rx_v    = rx_evt.valid;
   assign rx_len  = rx_evt.len;
   assign rx_max  = max_len_alt ? `LEN_ALT_MAX : `LEN_STD_MAX;
   assign rx_err  = !rx_evt.check_ok | rx_evt.bad_symbol |
                    rx_evt.misaligned;
   assign rx_good = rx_v & !rx_err;
   assign tx_v    = tx_evt.valid;
   assign tx_len  = tx_evt.len;
   assign tx_ok   = tx_v & tx_evt.good;

   // Length bin for the receive histogram
   always_comb begin
      if (rx_len <= `LEN_MIN)
         bin = 3'h0;
      else if (rx_len <= `LEN_B1)
         bin = 3'h1;
      else if (rx_len <= `LEN_B2)
         bin = 3'h2;
      else if (rx_len <= `LEN_B3)
         bin = 3'h3;
      else if (rx_len <= `LEN_B4)
         bin = 3'h4;
      else if (rx_len <= `LEN_STD_MAX)
         bin = 3'h5;
      else if (rx_len <= `LEN_B6)
         bin = 3'h6;
      else
         bin = 3'h7;
   end

   // Every matching counter gets its increment in the same cycle
   always_comb begin
      for (int k = 0; k < `NUM_CNT; k++) begin
         inc[k] = 14'h0000;
      end
      if (rx_v) begin
         if (rx_evt.high_prio)
            inc[`IDX_RX_HI_OCT] = rx_len;
         if (rx_len < `LEN_MIN && rx_evt.check_ok)
            inc[`IDX_RX_SHORT_OK] = 14'h0001;
         if (rx_len < `LEN_MIN && rx_err)
            inc[`IDX_RX_SHORT_BAD] = 14'h0001;
         if (rx_len > rx_max && rx_evt.check_ok)
            inc[`IDX_RX_LONG_OK] = 14'h0001;
         if (huge_only ? (rx_len > `LEN_HUGE)
                       : (rx_len > `LEN_STD_MAX && rx_err))
            inc[`IDX_RX_LONG_BAD] = 14'h0001;
         if (rx_evt.bad_symbol && rx_evt.preamble_ok &&
             rx_len >= `LEN_MIN && rx_len <= rx_max)
            inc[`IDX_RX_BAD_SYM] = 14'h0001;
         if (rx_len >= `LEN_MIN && rx_len <= rx_max &&
             !rx_evt.check_ok && !rx_evt.misaligned)
            inc[`IDX_RX_CHK_FAIL] = 14'h0001;
         if (rx_len >= `LEN_MIN && rx_len <= rx_max &&
             !rx_evt.check_ok && rx_evt.misaligned)
            inc[`IDX_RX_MISALIGN] = 14'h0001;
         if (rx_evt.mac_ctl)
            inc[`IDX_RX_MAC_CTL] = 14'h0001;
         if (rx_evt.mac_ctl && rx_evt.pause_op &&
             rx_len >= `LEN_MIN && rx_evt.check_ok)
            inc[`IDX_RX_PAUSE] = 14'h0001;
         if (rx_good && rx_evt.bcast)
            inc[`IDX_RX_BCAST] = 14'h0001;
         if (rx_good && rx_evt.mcast && !rx_evt.bcast &&
             !rx_evt.mac_ctl)
            inc[`IDX_RX_MCAST] = 14'h0001;
         if (rx_good && !rx_evt.mcast && !rx_evt.bcast)
            inc[`IDX_RX_UCAST] = 14'h0001;
         if (rx_len >= `LEN_MIN)
            inc[`IDX_RX_BIN0 + {3'h0, bin}] = 14'h0001;
         inc[`SLOT_RX_TOTAL] = rx_len;
      end
      if (tx_ok && tx_evt.high_prio)
         inc[`IDX_TX_HI_OCT] = tx_len;
      if (tx_late_coll)
         inc[`IDX_TX_LATE] = 14'h0001;
      if (tx_ok && tx_evt.mac_ctl && tx_evt.pause_op &&
          tx_len >= `LEN_MIN)
         inc[`IDX_TX_PAUSE] = 14'h0001;
      if (tx_ok && tx_evt.bcast)
         inc[`IDX_TX_BCAST] = 14'h0001;
      if (tx_ok && tx_evt.mcast && !tx_evt.bcast && !tx_evt.mac_ctl)
         inc[`IDX_TX_MCAST] = 14'h0001;
      if (tx_ok && !tx_evt.mcast && !tx_evt.bcast)
         inc[`IDX_TX_UCAST] = 14'h0001;
      if (tx_v && tx_evt.waited)
         inc[`IDX_TX_WAITED] = 14'h0001;
      if (tx_coll && half_duplex)
         inc[`IDX_TX_ALL_COLL] = 14'h0001;
      if (tx_v && tx_evt.abandoned)
         inc[`IDX_TX_ABANDON] = 14'h0001;
      if (tx_ok && tx_evt.coll_cnt == 5'h01)
         inc[`IDX_TX_ONE_COLL] = 14'h0001;
      if (tx_ok && tx_evt.coll_cnt > 5'h01)
         inc[`IDX_TX_MULTI] = 14'h0001;
      if (tx_v)
         inc[`SLOT_TX_TOTAL] = tx_len;
      if (rx_drop)
         inc[`SLOT_RX_DROP] = 14'h0001;
      if (tx_drop)
         inc[`SLOT_TX_DROP] = 14'h0001;
   end

   // Read-clear strobe for the slot being fetched
   always_comb begin
      rd_clr = '0;
      if (state_reg == stat_pkg::RD_FETCH && slot_ok)
         rd_clr[slot] = 1'b1;
   end

   // Counter bank, two wide byte totals
   for (genvar i = 0; i < `NUM_CNT; i++) begin : g_cnt
      localparam int W = (i == 32 || i == 33) ? `WIDE_W : `CNT_W;
      logic [W-1:0] v;
      stat_counter #(
         .W(W)
      ) u_cnt (
         .clk   (clk),
         .rst_n (rst_sync_n),
         .ce    (ce),
         .hold  (frozen),
         .clear (flush | rd_clr[i]),
         .inc   (inc[i]),
         .value (v),
         .ovf   (cnt_ovf[i])
      );
      assign cnt_val[i] = `WIDE_W'(v);
   end

   // Control-and-status register write fields
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         csr_index_reg <= `CSR_IDX_RST;
         flush_en_reg  <= 1'b0;
      end else if (ce && csr_wr) begin
         csr_index_reg <= csr_wdata[`CSR_IDX_HI:`CSR_IDX_LO];
         flush_en_reg  <= csr_wdata[`CSR_EN_BIT];
      end
   end

   // Read sequencer next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         stat_pkg::RD_IDLE: begin
            if (csr_wr && csr_wdata[`CSR_RD_BIT])
               state_next = stat_pkg::RD_FETCH;
         end
         stat_pkg::RD_FETCH: begin
            state_next = stat_pkg::RD_IDLE;
         end
         default: begin
            state_next = stat_pkg::RD_IDLE;
         end
      endcase
   end

   // Read sequencer state and busy flag
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_reg   <= stat_pkg::RD_IDLE;
         rd_busy_reg <= 1'b0;
      end else if (ce) begin
         state_reg   <= state_next;
         rd_busy_reg <= (state_next == stat_pkg::RD_FETCH);
      end
   end

   // Capture the count and the wide-counter extras
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         data_reg    <= `DATA_RST;
         data_hi_reg <= 4'h0;
         ovf_reg     <= 1'b0;
      end else if (ce && state_reg == stat_pkg::RD_FETCH) begin
         data_reg    <= slot_ok ? cnt_val[slot][31:0] : `DATA_RST;
         data_hi_reg <= slot_ok ? cnt_val[slot][35:32] : 4'h0;
         ovf_reg     <= slot_ok & cnt_ovf[slot];
      end
   end

   // Start of a read makes the busy flag rise then fall
   property p_rd_done;
      @(posedge clk) disable iff (!rst_sync_n)
      (ce && csr_wr && csr_wdata[`CSR_RD_BIT] && !rd_busy_reg) ##1 ce
      |-> rd_busy_reg ##1 !rd_busy_reg;
   endproperty
   a_rd_done: assert property (p_rd_done)
      else $error("busy flag did not complete read");

   // A fetched counter reads zero afterwards when idle
   property p_rd_clear;
      @(posedge clk) disable iff (!rst_sync_n)
      (ce && state_reg == stat_pkg::RD_FETCH && slot_ok &&
       inc[slot] == 14'h0000)
      |=> cnt_val[$past(slot)] == '0;
   endproperty
   a_rd_clear: assert property (p_rd_clear)
      else $error("counter not cleared by read");

   // Frozen counters never move without a clear
   property p_frozen;
      @(posedge clk) disable iff (!rst_sync_n)
      (ce && frozen && !flush && state_reg == stat_pkg::RD_IDLE)
      |=> $stable(cnt_val[`IDX_RX_HI_OCT]) && $stable(cnt_val[32]);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("frozen counter changed");

   // Flush with freeze empties every counter of an enabled port
   property p_flush;
      @(posedge clk) disable iff (!rst_sync_n)
      (ce && flush && frozen) |=> cnt_val[`IDX_RX_UCAST] == '0 &&
                                   cnt_val[`SLOT_TX_TOTAL] == '0;
   endproperty
   a_flush: assert property (p_flush)
      else $error("flush left a count");

   // Good short frame adds one
   property p_short_ok;
      @(posedge clk) disable iff (!rst_sync_n)
      (ce && !frozen && !flush && rd_clr == '0 && rx_v &&
       rx_len < `LEN_MIN && rx_evt.check_ok)
      |=> cnt_val[1][29:0] == $past(cnt_val[1][29:0]) + 30'h1;
   endproperty
   a_short_ok: assert property (p_short_ok)
      else $error("short good frame not counted");

   // High-priority receive octets follow frame lengths
   property p_rx_oct;
      @(posedge clk) disable iff (!rst_sync_n)
      (ce && !frozen && !flush && rd_clr == '0 && rx_v &&
       rx_evt.high_prio)
      |=> cnt_val[0][29:0] == $past(cnt_val[0][29:0]) +
                              30'($past(rx_len));
   endproperty
   a_rx_oct: assert property (p_rx_oct)
      else $error("high priority octets not added");

   // Broadcast never counts as unicast
   property p_bcast;
      @(posedge clk) disable iff (!rst_sync_n)
      (rx_good && rx_evt.bcast) |-> inc[`IDX_RX_UCAST] == 14'h0000 &&
                                    inc[`IDX_RX_BCAST] == 14'h0001;
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast classified wrongly");

   // A 64 byte frame lands in the first bin only
   property p_bin64;
      @(posedge clk) disable iff (!rst_sync_n)
      (rx_v && rx_len == `LEN_MIN) |-> inc[13] == 14'h0001 &&
                                       inc[14] == 14'h0000;
   endproperty
   a_bin64: assert property (p_bin64)
      else $error("64 byte frame in wrong bin");

   // Late collision pulse reaches its counter
   property p_late;
      @(posedge clk) disable iff (!rst_sync_n)
      (ce && !frozen && !flush && rd_clr == '0 && tx_late_coll)
      |=> cnt_val[22][29:0] == $past(cnt_val[22][29:0]) + 30'h1;
   endproperty
   a_late: assert property (p_late)
      else $error("late collision not counted");
endmodule // port_statistics_counters

// [stat_cfg.svh]
// Purpose: Constants for the per-port statistics counter bank
// Assumes: Included by bare name from the design files
// Notes:   Indices are the software-visible counter numbers
// Overview of operation
// - Thirty-six counters per port, indirect access only
// - One global flush and freeze control
// - Index 0x00 adds high-priority receive octets
// - Index 0x01 counts short frames, good check
// - Index 0x02 counts short frames with errors
// - Index 0x03 counts long frames, good check
// - Index 0x04 counts long errored or huge frames
// - Index 0x05 counts legal frames with bad symbols
// - Index 0x06 counts whole-byte frames failing check
// - Index 0x07 counts fractional-byte frames failing check
// - Index 0x08 counts received MAC control frames
// - Index 0x09 counts received valid pause frames
// - Indices 0x0A-0x0C count good receive destination kinds
// - Indices 0x0D-0x14 count receive length bins
// - Index 0x15 adds good high-priority transmit octets
// - Index 0x16 counts late collisions
// - Index 0x17 counts transmitted valid pause frames
// - Indices 0x18-0x1A count good transmit destination kinds
// - Index 0x1B counts deferred first transmit attempts
// - Indices 0x1C-0x1F count collision outcomes
// - Indices 0x80-0x83 hold totals and resource drops
// - Reading a counter restarts it from its fetch-cycle increment, zero if frozen
// - Index at 23:16, bit 25 starts, clears
// - Wide counters show top bits and overflow
// - Global 0x40 freezes, 0xC0 clears, enabled ports
`ifndef STAT_CFG_SVH
`define STAT_CFG_SVH
// Counter geometry
`define NUM_CNT          36
`define CNT_W            30
`define WIDE_W           36
`define LEN_W            14
// Control register fields
`define CSR_IDX_HI       23
`define CSR_IDX_LO       16
`define CSR_EN_BIT       24
`define CSR_RD_BIT       25
`define GCTL_FREEZE_BIT  6
`define GCTL_FLUSH_BIT   7
// Reset values
`define CSR_IDX_RST      8'h00
`define DATA_RST         32'h0000_0000
// Receive indices
`define IDX_RX_HI_OCT    6'h00
`define IDX_RX_SHORT_OK  6'h01
`define IDX_RX_SHORT_BAD 6'h02
`define IDX_RX_LONG_OK   6'h03
`define IDX_RX_LONG_BAD  6'h04
`define IDX_RX_BAD_SYM   6'h05
`define IDX_RX_CHK_FAIL  6'h06
`define IDX_RX_MISALIGN  6'h07
`define IDX_RX_MAC_CTL   6'h08
`define IDX_RX_PAUSE     6'h09
`define IDX_RX_BCAST     6'h0A
`define IDX_RX_MCAST     6'h0B
`define IDX_RX_UCAST     6'h0C
`define IDX_RX_BIN0      6'h0D
// Transmit indices
`define IDX_TX_HI_OCT    6'h15
`define IDX_TX_LATE      6'h16
`define IDX_TX_PAUSE     6'h17
`define IDX_TX_BCAST     6'h18
`define IDX_TX_MCAST     6'h19
`define IDX_TX_UCAST     6'h1A
`define IDX_TX_WAITED    6'h1B
`define IDX_TX_ALL_COLL  6'h1C
`define IDX_TX_ABANDON   6'h1D
`define IDX_TX_ONE_COLL  6'h1E
`define IDX_TX_MULTI     6'h1F
// Extended indices (0x80-0x83) and their slots
`define IDX_EXT_BASE     8'h80
`define SLOT_RX_TOTAL    6'h20
`define SLOT_TX_TOTAL    6'h21
`define SLOT_RX_DROP     6'h22
`define SLOT_TX_DROP     6'h23
// Frame length limits in bytes
`define LEN_MIN          14'h0040
`define LEN_STD_MAX      14'h05F2
`define LEN_ALT_MAX      14'h0600
`define LEN_HUGE         14'h077C
`define LEN_B1           14'h007F
`define LEN_B2           14'h00FF
`define LEN_B3           14'h01FF
`define LEN_B4           14'h03FF
`define LEN_B6           14'h07D0
`endif

// [stat_pkg.sv]
// Purpose: Types shared by the statistics counter bank
// Assumes: Lengths fit in 14 bits
// Notes:   Event structs are sampled on one-cycle valid pulses
package stat_pkg;
   // One finished receive frame
   typedef struct packed {
      logic        valid;
      logic [13:0] len;
      logic        high_prio;
      logic        check_ok;
      logic        bad_symbol;
      logic        misaligned;
      logic        preamble_ok;
      logic        bcast;
      logic        mcast;
      logic        mac_ctl;
      logic        pause_op;
   } rx_event_t;
   // One finished transmit attempt
   typedef struct packed {
      logic        valid;
      logic [13:0] len;
      logic        high_prio;
      logic        good;
      logic        bcast;
      logic        mcast;
      logic        mac_ctl;
      logic        pause_op;
      logic        waited;
      logic        abandoned;
      logic [4:0]  coll_cnt;
   } tx_event_t;
   // Indirect read sequencer
   typedef enum logic [1:0] {
      RD_IDLE  = 2'b01,
      RD_FETCH = 2'b10
   } rd_state_t;
endpackage

// [stat_counter.sv]
// Purpose: One statistics accumulator with clear and hold
// Assumes: Clear wins over hold; an increment in a clear cycle survives unless hold is set
// Notes:   Overflow is sticky until the next clear
`timescale 1ns/1ps
module stat_counter #(
   parameter int W = 30
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // Control
   input  wire logic         hold,
   input  wire logic         clear,
   input  wire logic [13:0]  inc,
   // Value
   output logic      [W-1:0] value,
   output logic              ovf
);
   logic [W:0] sum;

   // Widened sum to catch the carry
   assign sum = {1'b0, value} + {{(W-13){1'b0}}, inc};

   // Count, hold or clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         value <= '0;
         ovf   <= 1'b0;
      end else if (ce) begin
         if (clear) begin
            value <= hold ? '0 : {{(W-14){1'b0}}, inc};
            ovf   <= 1'b0;
         end else if (!hold) begin
            value <= sum[W-1:0];
            if (sum[W])
               ovf <= 1'b1;
         end
      end
   end
endmodule // stat_counter

// [mac_evt_model.sv]
// Purpose: Far-side MAC event source for the statistics bank
// Assumes: Events are driven 1 ns after a rising clock edge
// Notes:   Idle event fields carry scrambled values, not the last frame
`timescale 1ns/1ps
module mac_evt_model (
   // Clock
   input  wire logic                clk,
   // Event outputs
   output var stat_pkg::rx_event_t  rx_evt,
   output var stat_pkg::tx_event_t  tx_evt,
   output logic [3:0]               pulses
);
   // Quiet start
   initial begin
      rx_evt = '0;
      tx_evt = '0;
      pulses = 4'h0;
   end
   // One receive frame report, fields inverted once valid drops
   task automatic rx(input logic [13:0] l, input logic [8:0] f);
      @(posedge clk);
      #1 rx_evt = {1'b1, l, f};
      @(posedge clk);
      #1 rx_evt = {1'b0, ~l, ~f};
   endtask
   // One transmit attempt report
   task automatic tx(input logic [13:0] l, input logic [7:0] f,
                     input logic [4:0] c);
      @(posedge clk);
      #1 tx_evt = {1'b1, l, f, c};
      @(posedge clk);
      #1 tx_evt = {1'b0, ~l, ~f, ~c};
   endtask
   // Late collision, collision, rx drop, tx drop pulses
   task automatic pulse(input logic [3:0] p);
      @(posedge clk);
      #1 pulses = p;
      @(posedge clk);
      #1 pulses = 4'h0;
   endtask
endmodule // mac_evt_model

// [tb_top.sv]
// Purpose: Self-checking bench for the per-port statistics bank
// Assumes: Clock enable high except in one hold check; one read at a time
// Notes:   Reads clear counters, so each check sees fresh counts
`timescale 1ns/1ps
module tb_top;
   logic                clk, rst_n, csr_wr, en, ce;
   logic                max_len_alt, huge_only, half_duplex;
   logic [31:0]         csr_wdata, data_reg;
   logic [7:0]          glob_ctl, csr_index_reg;
   logic [3:0]          pulses, data_hi_reg;
   logic                flush_en_reg, rd_busy_reg, ovf_reg;
   logic [13:0]         bl [4];
   stat_pkg::rx_event_t rx_evt;
   stat_pkg::tx_event_t tx_evt;
   int                  err_total, num_checks;
   // Device under test
   port_statistics_counters u_dut (.clk(clk), .ce(ce), .rst_n(rst_n),
      .csr_wr(csr_wr), .csr_wdata(csr_wdata), .glob_ctl(glob_ctl),
      .max_len_alt(max_len_alt), .huge_only(huge_only),
      .half_duplex(half_duplex), .rx_evt(rx_evt), .tx_evt(tx_evt),
      .tx_late_coll(pulses[3]), .tx_coll(pulses[2]),
      .rx_drop(pulses[1]), .tx_drop(pulses[0]),
      .csr_index_reg(csr_index_reg), .flush_en_reg(flush_en_reg),
      .rd_busy_reg(rd_busy_reg), .data_hi_reg(data_hi_reg),
      .ovf_reg(ovf_reg), .data_reg(data_reg));
   // MAC side
   mac_evt_model u_mac (.clk(clk), .rx_evt(rx_evt), .tx_evt(tx_evt),
      .pulses(pulses));
   // Clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [35:0] s, e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Indirect counter read through the control word
   task automatic rd(input logic [7:0] idx, input logic [35:0] e);
      int n;
      n = 0;
      @(posedge clk);
      #1 csr_wr = 1'b1;
      csr_wdata = {6'h00, 1'b1, en, idx, 16'h0000};
      @(posedge clk);
      #1 csr_wr = 1'b0;
      chk("busy", 36'(rd_busy_reg), 36'h1);
      chk("index", 36'(csr_index_reg), 36'(idx));
      chk("enable", 36'(flush_en_reg), 36'(en));
      while (rd_busy_reg !== 1'b0 && n < 8) begin
         @(posedge clk);
         #1 n++;
      end
      chk("count", {data_hi_reg, data_reg}, e);
      chk("ovf", 36'(ovf_reg), 36'h0);
   endtask
   // Switch-wide control value
   task automatic gset(input logic [7:0] v);
      @(posedge clk);
      #1 glob_ctl = v;
   endtask
   // Verdict
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      wrap_up;
   end
   // Main sequence
   initial begin
      {rst_n, csr_wr, en, max_len_alt, huge_only, half_duplex} = 6'h00;
      ce = 1'b1;
      csr_wdata = 32'h0000_0000;
      glob_ctl = 8'h00;
      bl = '{14'h0FF, 14'h1FF, 14'h3FF, 14'h5F2};
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("reset", {data_hi_reg, data_reg}, 36'h0);
      chk("rst_ctl", 36'({rd_busy_reg, ovf_reg, flush_en_reg,
          csr_index_reg}), 36'h0);
      u_mac.rx(14'h040, 9'h190);
      rd(8'h00, 36'h40);
      rd(8'h0C, 36'h1);
      rd(8'h0C, 36'h0);
      rd(8'h0D, 36'h1);
      rd(8'h80, 36'h40);
      u_mac.rx(14'h041, 9'h098);
      rd(8'h0A, 36'h1);
      rd(8'h0B, 36'h0);
      rd(8'h0E, 36'h1);
      u_mac.rx(14'h028, 9'h090);
      rd(8'h01, 36'h1);
      u_mac.rx(14'h028, 9'h010);
      rd(8'h02, 36'h1);
      u_mac.rx(14'h5FA, 9'h090);
      rd(8'h03, 36'h1);
      max_len_alt = 1'b1;
      u_mac.rx(14'h5FA, 9'h090);
      rd(8'h03, 36'h0);
      rd(8'h13, 36'h2);
      max_len_alt = 1'b0;
      u_mac.rx(14'h640, 9'h010);
      rd(8'h04, 36'h1);
      huge_only = 1'b1;
      u_mac.rx(14'h834, 9'h090);
      rd(8'h04, 36'h1);
      rd(8'h14, 36'h1);
      huge_only = 1'b0;
      u_mac.rx(14'h064, 9'h010);
      rd(8'h06, 36'h1);
      u_mac.rx(14'h064, 9'h030);
      rd(8'h07, 36'h1);
      u_mac.rx(14'h064, 9'h050);
      rd(8'h05, 36'h1);
      u_mac.rx(14'h040, 9'h097);
      u_mac.rx(14'h040, 9'h094);
      rd(8'h08, 36'h1);
      rd(8'h09, 36'h1);
      rd(8'h0B, 36'h1);
      for (int k = 0; k < 4; k++) u_mac.rx(bl[k], 9'h090);
      for (int k = 0; k < 4; k++) rd(8'h0F + 8'(k), 36'h1);
      rd(8'h0C, 36'h8);
      u_mac.tx(14'h064, 8'hE0, 5'h00);
      rd(8'h15, 36'h64);
      rd(8'h18, 36'h1);
      rd(8'h81, 36'h64);
      u_mac.tx(14'h040, 8'hDC, 5'h00);
      rd(8'h17, 36'h1);
      rd(8'h19, 36'h0);
      rd(8'h15, 36'h40);
      u_mac.tx(14'h050, 8'h52, 5'h01);
      rd(8'h19, 36'h1);
      rd(8'h1B, 36'h1);
      rd(8'h1E, 36'h1);
      u_mac.tx(14'h050, 8'h40, 5'h03);
      rd(8'h1A, 36'h1);
      rd(8'h1F, 36'h1);
      u_mac.tx(14'h050, 8'h01, 5'h10);
      rd(8'h1D, 36'h1);
      rd(8'h1A, 36'h0);
      half_duplex = 1'b1;
      u_mac.pulse(4'hF);
      half_duplex = 1'b0;
      u_mac.pulse(4'h4);
      rd(8'h16, 36'h1);
      rd(8'h1C, 36'h1);
      rd(8'h82, 36'h1);
      rd(8'h83, 36'h1);
      en = 1'b1;
      rd(8'h40, 36'h0);
      gset(8'h40);
      u_mac.rx(14'h040, 9'h190);
      gset(8'h00);
      rd(8'h0C, 36'h0);
      u_mac.rx(14'h040, 9'h190);
      gset(8'hC0);
      gset(8'h00);
      rd(8'h0C, 36'h0);
      en = 1'b0;
      rd(8'h84, 36'h0);
      gset(8'h40);
      u_mac.rx(14'h040, 9'h190);
      gset(8'h00);
      rd(8'h0C, 36'h1);
      ce = 1'b0;
      u_mac.rx(14'h040, 9'h090);
      ce = 1'b1;
      rd(8'h0C, 36'h0);
      wrap_up;
   end
endmodule // tb_top
